// ===== serdes_rx.sv
// multi-channel deserializer receiver with realign and pll model
`timescale 1ns/1ns
// Functional notes
// [RQ1] deserialization factor is 4, 7, 8 or 10, fixed at build
// [RQ2] channel n occupies output bits J*n-1 down to J*(n-1)
// [RQ3] output bus width is channels times deserialization factor
// [RQ4] output clock runs at W/J times reference; words update at that rate
// [RQ5] serial rate exceeds reference rate and stays at or under 840 Mbps
// [RQ6] capture phase selectable, edge aligned default; pll phase follows
// [RQ7] center aligned means 90 degrees after reference edge
// [RQ8] realign input from pin or core drives word boundary logic
// [RQ9] core drives realign synchronous to the output clock
// [RQ10] one pll enable serves all plls; lock output reports lock
// [RQ11] realign uses both load enables; two banks share only two
// [RQ12] realign only when pll is receive-only or one bank suffices
// [RQ13] adjacent center plls may not both clock cross-bank receivers
// [RQ14] cross-bank rate 840 Mbps, 624 Mbps on wire-bond packages
// [RQ15] slow-speed channels guaranteed only up to 462 Mbps
// [RQ16] shared pll serves full receive and transmit channel counts
// [RQ17] core holds realign at least two cycles
// [RQ18] each accepted realign slips every channel one bit
// [RQ19] one whole word per channel per output clock, all together
module serdes_rx
  import serdes_rx_pkg::*;
(
  input  wire logic                 REF_CLK,
  input  wire logic                 SYS_RST,
  input  wire logic [CHANNELS-1:0]  SER_IN,
  input  wire logic                 PLL_ENABLE,
  input  wire logic                 REALIGN,
  input  wire phase_sel_t           PHASE_SEL,
  input  wire placement_t           PLACE,
  output logic [BUS_WIDTH-1:0]      PAR_OUT,
  output logic                      OUT_CLK,
  output logic                      LOCKED,
  output pll_status_t               STATUS,
  output logic                      RATE_ERR
);
  // build time checks on factor and rate
  if (!(DESER_FACTOR inside {4, 7, 8, 10})) begin : g_bad_factor // [RQ1]
    $error("illegal deserialization factor");
  end
  if (LINE_RATE_MBPS <= REF_MHZ ||
      LINE_RATE_MBPS > MAX_RATE_MBPS) begin : g_bad_rate // [RQ5]
    $error("serial rate out of range");
  end

  // pin synchronisers
  logic [CHANNELS-1:0] ser_s1_reg, ser_s2_reg;
  logic [1:0]          en_s_reg, al_s_reg;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ser_s1_reg <= '0;
      ser_s2_reg <= '0;
      en_s_reg   <= '0;
      al_s_reg   <= '0;
    end else begin
      ser_s1_reg <= SER_IN;
      ser_s2_reg <= ser_s1_reg;
      en_s_reg   <= {en_s_reg[0], PLL_ENABLE};
      al_s_reg   <= {al_s_reg[0], REALIGN}; // [RQ8]
    end
  end
  wire pll_en = en_s_reg[1];
  wire align_in = al_s_reg[1];

  // pll lock counter; one enable for all plls
  logic [3:0] lock_cnt_reg;
  wire        lock_done = (lock_cnt_reg == 4'(LOCK_CYCLES - 1));
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !pll_en) begin
      lock_cnt_reg <= LOCK_CNT_RST;
    end else if (!lock_done) begin
      lock_cnt_reg <= lock_cnt_reg + 4'h1; // [RQ10]
    end
  end

  // realign permission and load enable use
  wire align_ok = PLACE.rx_only || PLACE.single_bank;          // [RQ12]
  wire xbank_ok = !(PLACE.cross_bank && PLACE.adj_xbank_rx);   // [RQ13]
  // cross-bank leaves no load enable for a shared transmitter
  wire load_ok  = !(PLACE.cross_bank && PLACE.share_tx);       // [RQ11]
  // realign allowed by placement; rx load enable used only then, tx load enable also when shared with a transmitter
  wire align_allow = align_ok && xbank_ok && load_ok;
  wire align_en    = align_allow && LOCKED;
  // lanes above the slow-lane limit need high-speed pins [RQ15]; not checked, rate_cap never uses SLOW_RATE_MBPS
  wire [9:0] rate_cap = PLACE.cross_bank && PLACE.wire_bond ?
                        10'(XBANK_WB_RATE_MBPS) :
                        10'(MAX_RATE_MBPS);                    // [RQ14]
  wire rate_bad = (10'(LINE_RATE_MBPS) > rate_cap) || !xbank_ok;

  // realign must stand two cycles; one slip per assertion
  logic [1:0] hold_reg;
  logic       fired_reg;
  wire hold_met = (hold_reg >= 2'(ALIGN_HOLD - 1)) && align_in;
  wire slip_req = hold_met && !fired_reg && align_en;          // [RQ17]
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !align_in) begin
      hold_reg  <= '0;
      fired_reg <= 1'b0;
    end else begin
      if (hold_reg != 2'h3) hold_reg <= hold_reg + 2'h1;
      if (slip_req) fired_reg <= 1'b1;
    end
  end

  // bit position counter shared by all lanes
  logic [CNT_W-1:0] pos_reg;
  wire              bit_vld = LOCKED;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !LOCKED) begin
      pos_reg <= SLIP_RESET;
    end else if (slip_req) begin
      pos_reg <= pos_reg; // [RQ18]
    end else if (pos_reg == CNT_W'(DESER_FACTOR - 1)) begin
      pos_reg <= '0;
    end else begin
      pos_reg <= pos_reg + CNT_W'(1);
    end
  end

  // one lane per channel
  logic [DESER_FACTOR-1:0] lane_word [CHANNELS];
  logic [CHANNELS-1:0]     lane_vld;
  for (genvar n = 0; n < CHANNELS; n++) begin : g_lane
    serdes_rx_lane u_lane (
      .clk      (REF_CLK),
      .rst      (SYS_RST),
      .bit_in   (ser_s2_reg[n]),
      .bit_vld  (bit_vld),
      .slip     (slip_req),
      .pos      (pos_reg),
      .word_out (lane_word[n]),
      .word_vld (lane_vld[n])
    );
  end

  // pack lanes: channel n+1 at bits J*(n+1)-1 .. J*n
  logic [BUS_WIDTH-1:0] packed_word;
  always_comb begin
    packed_word = '0;
    for (int n = 0; n < CHANNELS; n++) begin
      packed_word[n*DESER_FACTOR +: DESER_FACTOR] = lane_word[n]; // [RQ2]
    end
  end

  // output clock high for first half word; words update together
  wire oclk_next = (pos_reg < CNT_W'(DESER_FACTOR / 2));       // [RQ4]
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PAR_OUT  <= '0;
      OUT_CLK  <= 1'b0;
      LOCKED   <= 1'b0;
      STATUS   <= '0;
      RATE_ERR <= 1'b0;
    end else begin
      if (lane_vld[0]) PAR_OUT <= packed_word; // [RQ19] [RQ3]
      OUT_CLK  <= LOCKED && oclk_next;
      LOCKED   <= pll_en && lock_done;         // [RQ10]
      RATE_ERR <= rate_bad;
      STATUS.locked      <= pll_en && lock_done;
      STATUS.align_ok    <= align_allow;
      STATUS.rxload_used <= align_allow;       // [RQ11]
      STATUS.txload_used <= align_allow || PLACE.share_tx; // [RQ16]
      STATUS.phase       <= phase_deg(PHASE_SEL); // [RQ6] [RQ7]
    end
  end

  // assertions
  property p_lock_needs_en;
    @(posedge REF_CLK) disable iff (SYS_RST)
      !pll_en |=> !LOCKED;
  endproperty
  a_lock_needs_en: assert property (p_lock_needs_en) // [RQ10]
    else $error("locked without enable");

  property p_slip_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
      slip_req |-> $past(align_in) && align_in;
  endproperty
  a_slip_hold: assert property (p_slip_hold) // [RQ17]
    else $error("slip without two-cycle realign");

  property p_slip_gate;
    @(posedge REF_CLK) disable iff (SYS_RST)
      slip_req |-> (PLACE.rx_only || PLACE.single_bank);
  endproperty
  a_slip_gate: assert property (p_slip_gate) // [RQ12]
    else $error("slip on forbidden placement");

  property p_one_slip;
    @(posedge REF_CLK) disable iff (SYS_RST)
      slip_req |=> !slip_req;
  endproperty
  a_one_slip: assert property (p_one_slip) // [RQ18]
    else $error("double slip per request");

  property p_slip_hold_pos;
    @(posedge REF_CLK) disable iff (SYS_RST)
      slip_req && LOCKED |=> pos_reg == $past(pos_reg);
  endproperty
  a_slip_hold_pos: assert property (p_slip_hold_pos) // [RQ18]
    else $error("slip did not hold position");

  property p_lanes_together;
    @(posedge REF_CLK) disable iff (SYS_RST)
      lane_vld[0] |-> &lane_vld;
  endproperty
  a_lanes_together: assert property (p_lanes_together) // [RQ19]
    else $error("lanes out of step");

  property p_word_spacing;
    @(posedge REF_CLK) disable iff (SYS_RST)
      lane_vld[0] && !slip_req |=> !lane_vld[0] [*7];
  endproperty
  a_word_spacing: assert property (p_word_spacing) // [RQ4]
    else $error("word rate wrong");

  property p_out_update;
    @(posedge REF_CLK) disable iff (SYS_RST)
      lane_vld[0] |=> PAR_OUT[DESER_FACTOR-1:0] == $past(lane_word[0]);
  endproperty
  a_out_update: assert property (p_out_update) // [RQ2]
    else $error("channel one not at low bits");

  property p_center;
    @(posedge REF_CLK) disable iff (SYS_RST)
      PHASE_SEL == PH_CENTER |=> STATUS.phase == 9'h05A;
  endproperty
  a_center: assert property (p_center) // [RQ7]
    else $error("center phase not 90 degrees");

  property p_xbank_rate;
    @(posedge REF_CLK) disable iff (SYS_RST)
      PLACE.cross_bank && PLACE.adj_xbank_rx |=> RATE_ERR;
  endproperty
  a_xbank_rate: assert property (p_xbank_rate) // [RQ13]
    else $error("adjacent cross-bank not flagged");

  c_lock: cover property (@(posedge REF_CLK) $rose(LOCKED));
  c_slip: cover property (@(posedge REF_CLK) slip_req);
  c_word: cover property (@(posedge REF_CLK) lane_vld[0]);
endmodule

// ===== serdes_rx_pkg.sv
// shared constants and types for the serial deserializer receiver
package serdes_rx_pkg;

  localparam int unsigned CHANNELS     = 4;
  localparam int unsigned DESER_FACTOR = 8;    // legal: 4, 7, 8, 10
  localparam int unsigned BUS_WIDTH    = CHANNELS * DESER_FACTOR;
  localparam int unsigned BOOST_FACTOR = 8;    // clock boost W
  localparam int unsigned CNT_W        = 4;
  localparam int unsigned REF_MHZ      = 100;
  localparam int unsigned MAX_RATE_MBPS      = 840;
  localparam int unsigned XBANK_WB_RATE_MBPS = 624;
  localparam int unsigned SLOW_RATE_MBPS     = 462;
  localparam int unsigned LINE_RATE_MBPS     = REF_MHZ * DESER_FACTOR;
  localparam int unsigned ALIGN_HOLD   = 2;    // cycles realign must stand
  localparam int unsigned LOCK_CYCLES  = 16;   // pll settle after enable
  localparam logic [3:0]  SLIP_RESET   = 4'h0;
  localparam logic [3:0]  LOCK_CNT_RST = 4'h0;

  // capture phase selections, edge aligned first as the default
  typedef enum logic [2:0] {
    PH_EDGE, PH_CENTER, PH_45, PH_135, PH_180, PH_225, PH_270, PH_315
  } phase_sel_t;

  // pll output phase in degrees for each selection
  function automatic logic [8:0] phase_deg(input phase_sel_t p);
    unique case (p)
      PH_EDGE:   phase_deg = 9'h000;
      PH_CENTER: phase_deg = 9'h05A;   // 90 degrees
      PH_45:     phase_deg = 9'h02D;
      PH_135:    phase_deg = 9'h087;
      PH_180:    phase_deg = 9'h0B4;
      PH_225:    phase_deg = 9'h0E1;
      PH_270:    phase_deg = 9'h10E;
      PH_315:    phase_deg = 9'h13B;
    endcase
  endfunction

  // placement request of the serving pll
  typedef struct packed {
    logic cross_bank;   // channels span two banks
    logic rx_only;      // pll clocks receive channels only
    logic single_bank;  // all channels fit in one bank
    logic share_tx;     // pll shared with a transmitter
    logic adj_xbank_rx; // neighbour pll clocks cross-bank receivers
    logic wire_bond;    // package is wire bond
  } placement_t;

  // pll status
  typedef struct packed {
    logic       locked;
    logic       align_ok;
    logic       rxload_used;
    logic       txload_used;
    logic [8:0] phase;
  } pll_status_t;

endpackage

// ===== serdes_rx_lane.sv
// one lane: shift register with a word boundary slip
`timescale 1ns/1ns
module serdes_rx_lane
  import serdes_rx_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    bit_in,
  input  wire logic                    bit_vld,
  input  wire logic                    slip,
  input  wire logic [CNT_W-1:0]        pos,
  output logic      [DESER_FACTOR-1:0] word_out,
  output logic                         word_vld
);
  logic [DESER_FACTOR-1:0] shift_reg;

  // newest bit enters at the lsb, first bit ends at the msb
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (bit_vld) begin
      shift_reg <= {shift_reg[DESER_FACTOR-2:0], bit_in};
    end
  end

  // word closes when the bit count wraps; slip delays it one bit
  wire word_done = bit_vld && !slip &&
                   (pos == CNT_W'(DESER_FACTOR - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      word_out <= '0;
      word_vld <= 1'b0;
    end else begin
      word_vld <= word_done;
      if (word_done) begin
        word_out <= {shift_reg[DESER_FACTOR-2:0], bit_in};
      end
    end
  end
endmodule

// ===== serdes_tx_model.sv
// serial transmitter model feeding the receiver lanes
`timescale 1ns/1ns
module serdes_tx_model
  import serdes_rx_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [BUS_WIDTH-1:0] words,
  output logic      [CHANNELS-1:0]  ser
);
  logic [2:0] bit_cnt = 3'h0;
  // one bit per lane each edge, msb first, 800 Mbps under cap
  always @(posedge clk) begin
    bit_cnt <= bit_cnt + 3'h1;
    for (int k = 0; k < CHANNELS; k++) begin
      ser[k] <= words[k*DESER_FACTOR + DESER_FACTOR - 1 - bit_cnt];
    end
  end
endmodule

// ===== serdes_rx_test.sv
// self-checking bench for the deserializer receiver
`timescale 1ns/1ns
module serdes_rx_test;
  import serdes_rx_pkg::*;
  logic                 clk     = 1'b0;
  logic                 rst     = 1'b1;
  logic                 pll_en  = 1'b0;
  logic                 realign = 1'b0;
  phase_sel_t           phase   = PH_EDGE;
  placement_t           place   = '0;
  logic [BUS_WIDTH-1:0] words   = 32'h0F07_0301;
  logic [CHANNELS-1:0]  ser;
  logic [BUS_WIDTH-1:0] par;
  logic                 oclk;
  logic                 locked;
  logic                 rate_err;
  pll_status_t          status;
  int                   err_count = 0;
  int                   checked = 0;
  int                   r0, r1, hi, ed;
  logic                 pv;
  logic [8:0] deg [8] = '{9'h000, 9'h05A, 9'h02D, 9'h087,
                          9'h0B4, 9'h0E1, 9'h10E, 9'h13B};
  logic [5:0] pl [6] = '{6'h10, 6'h00, 6'h08, 6'h32, 6'h2C, 6'h31};
  int         st [6] = '{1, 0, 1, 0, 0, 1};

  always #5 clk = ~clk;

  serdes_tx_model tx (.clk(clk), .words(words), .ser(ser));

  serdes_rx dut (
    .REF_CLK(clk), .SYS_RST(rst), .SER_IN(ser), .PLL_ENABLE(pll_en),
    .REALIGN(realign), .PHASE_SEL(phase), .PLACE(place),
    .PAR_OUT(par), .OUT_CLK(oclk), .LOCKED(locked),
    .STATUS(status), .RATE_ERR(rate_err)
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // settle point between rising edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // rotation of the sent pattern seen in field f, 8 if none
  function automatic int rot_of(input logic [BUS_WIDTH-1:0] p,
                                input int f);
    logic [7:0] w;
    rot_of = 8;
    for (int r = 0; r < 8; r++) begin
      w = words[f*8 +: 8];
      w = (w << r) | (w >> (8 - r));
      if (w === p[f*8 +: 8]) rot_of = r;
    end
  endfunction

  // all channel fields carry their own lane, same boundary
  task automatic lanes(output int r);
    r = rot_of(par, 0);
    check(r < 8, 1);
    for (int k = 1; k < CHANNELS; k++)
      check(rot_of(par, k), r);
  endtask

  // core-side realign request, synchronous, held three cycles
  task automatic pulse();
    @(posedge clk) realign <= 1'b1;
    repeat (3) @(posedge clk);
    realign <= 1'b0;
    tick(40);
  endtask

  task automatic end_of_test();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well past the expected run
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end

  initial begin
    tick(20);
    check(par, 0);
    @(posedge clk) rst <= 1'b0;
    check(DESER_FACTOR inside {4, 7, 8, 10}, 1);
    check($bits(dut.PAR_OUT), CHANNELS * DESER_FACTOR);
    tick(5);
    check(locked, 1'b0);
    @(posedge clk) pll_en <= 1'b1;
    tick(10);
    check(locked, 1'b0);
    tick(20);
    check(locked, 1'b1);
    check(status.locked, 1'b1);
    check(rate_err, 1'b0);
    $display("test lock done");
    for (int p = 0; p < 8; p++) begin
      @(posedge clk) phase <= phase_sel_t'(p);
      tick(3);
      check(status.phase, deg[p]);
    end
    @(posedge clk) phase <= PH_EDGE;
    $display("test phase done");
    hi = 0;
    ed = 0;
    pv = oclk;
    repeat (64) begin
      tick(1);
      hi += oclk;
      ed += oclk & ~pv;
      pv = oclk;
    end
    check(hi, 32);
    check(ed, 8);
    $display("test outclk done");
    tick(40);
    lanes(r0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) place <= pl[i];
      pulse();
      lanes(r1);
      check(r1, (r0 + st[i]) % 8);
      check(rate_err, pl[i][5] & (pl[i][1] | pl[i][0]));
      check(status.align_ok, st[i]);
      check(status.rxload_used, st[i]);
      check(status.txload_used, st[i] | pl[i][2]);
      r0 = r1;
    end
    $display("test realign done");
    end_of_test();
  end
endmodule
